/* core/mtrs_pkg.sv */
// Shared constants, modes, states and carriers for the timing relay sequencer
package mtrs_pkg;

  // ==========================================================
  // Clock and time base
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int NS_PER_MS = 1_000_000;

  // ==========================================================
  // Fixed intervals, in milliseconds and in ticks
  localparam int DEB_MS = 10;
  localparam int DEB_TICKS = (DEB_MS * NS_PER_MS + TICK_NS - 1) / TICK_NS;
  localparam int PULSE_MS = 500;
  localparam int BLINK_MS = 250;
  localparam int BLINK_TICKS = (BLINK_MS * NS_PER_MS) / TICK_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] PULSE_TICKS = CNT_W'((PULSE_MS * NS_PER_MS) / TICK_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] PRESET_RST = 16'h03E8;

  // ==========================================================
  // Function selection
  typedef enum logic [3:0] {
    MODE_RETRIG,
    MODE_FLASH_PAUSE,
    MODE_FLASH_ON,
    MODE_PULSE_GEN,
    MODE_SIG_ONOFF,
    MODE_LATCH,
    MODE_MAKE_BREAK,
    MODE_TRUE_OFF,
    MODE_ON_DELAY,
    MODE_OFF_DELAY,
    MODE_LEADING_SHOT,
    MODE_TRAILING_SHOT,
    MODE_PULSE_MON
  } mtrs_mode_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TIME,
    ST_TOFF,
    ST_PULSE,
    ST_HOLD,
    ST_DONE
  } mtrs_state_t;

  // ==========================================================
  // Output group
  typedef struct packed {
    logic relay;
    logic supply_timing_lamp;
    logic output_lamp;
  } mtrs_out_t;

endpackage

/* core/mtrs_tick_gen.sv */
// Time base tick and lamp blink generator
`timescale 1ns/1ps
`default_nettype none
module mtrs_tick_gen #(
  parameter int TICK_CYC = mtrs_pkg::TICK_CYC,
  parameter int BLINK_TICKS = mtrs_pkg::BLINK_TICKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  output var logic o_tick,
  output var logic o_blink
);
  import mtrs_pkg::*;

  logic [31:0] cyc;
  logic [31:0] blk;

  // ==========================================================
  // Tick prescaler
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else if (cyc >= 32'(TICK_CYC - 1)) begin
      cyc <= 32'h0000_0000;
      o_tick <= 1'b1;
    end else begin
      cyc <= cyc + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Blink phase
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk <= 32'h0000_0000;
      o_blink <= 1'b0;
    end else if (o_tick) begin
      if (blk >= 32'(BLINK_TICKS - 1)) begin
        blk <= 32'h0000_0000;
        o_blink <= !o_blink;
      end else begin
        blk <= blk + 32'h0000_0001;
      end
    end
  end

endmodule
`default_nettype wire

/* core/mtrs_sync_filter.sv */
// Pin synchroniser, tick debouncer and edge detector
`timescale 1ns/1ps
`default_nettype none
module mtrs_sync_filter #(
  parameter int DEB_TICKS = mtrs_pkg::DEB_TICKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_pin,
  output var logic o_level,
  output var logic o_rise,
  output var logic o_fall
);
  import mtrs_pkg::*;

  logic meta;
  logic sync;
  logic [7:0] deb;

  // ==========================================================
  // Two-stage synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
    end
  end

  // ==========================================================
  // Debounce and edges
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deb <= 8'h00;
      o_level <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (sync == o_level) begin
        deb <= 8'h00;
      end else if (i_tick) begin
        if (deb >= 8'(DEB_TICKS - 1)) begin
          deb <= 8'h00;
          o_level <= sync;
          o_rise <= sync;
          o_fall <= !sync;
        end else begin
          deb <= deb + 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* core/mtrs_sequencer.sv */
// Multifunction timing relay sequencer top
`timescale 1ns/1ps
`default_nettype none
module mtrs_sequencer #(
  parameter int TICK_CYC = mtrs_pkg::TICK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire mtrs_pkg::mtrs_mode_t i_mode,
  input wire logic [mtrs_pkg::CNT_W-1:0] i_preset,
  input wire logic i_ctrl,
  input wire logic i_supply,
  output var mtrs_pkg::mtrs_out_t o_status
);
  import mtrs_pkg::*;

  logic tick;
  logic blink;
  logic ctrl;
  logic ctrl_rise;
  logic ctrl_fall;
  logic sup;
  logic sup_rise;
  logic sup_fall;
  mtrs_mode_t mode_q;
  mtrs_state_t state;
  mtrs_state_t next_state;
  logic relay;
  logic next_relay;
  logic restart;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic timing;
  logic expire;
  logic mode_chg;
  logic lamp;

  // ==========================================================
  // Time base and inputs
  mtrs_tick_gen #(.TICK_CYC(TICK_CYC), .BLINK_TICKS(BLINK_TICKS)) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick),
    .o_blink(blink)
  );

  // Control contact filter
  mtrs_sync_filter #(.DEB_TICKS(DEB_TICKS)) u_ctrl (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_pin(i_ctrl),
    .o_level(ctrl),
    .o_rise(ctrl_rise),
    .o_fall(ctrl_fall)
  );

  mtrs_sync_filter #(.DEB_TICKS(DEB_TICKS)) u_sup (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_pin(i_supply),
    .o_level(sup),
    .o_rise(sup_rise),
    .o_fall(sup_fall)
  );

  // ==========================================================
  // Interval timer
  assign timing = (state == ST_TIME) || (state == ST_TOFF) || (state == ST_PULSE);
  assign limit = (state == ST_PULSE) ? PULSE_TICKS : i_preset;
  assign expire = timing && tick && ((cnt + CNT_ONE) >= limit);
  assign mode_chg = (i_mode != mode_q);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= CNT_ZERO;
    end else if (restart) begin
      cnt <= CNT_ZERO;
    end else if (timing && tick) begin
      cnt <= cnt + CNT_ONE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= MODE_RETRIG;
    end else begin
      mode_q <= i_mode;
    end
  end

  // ==========================================================
  // Function sequencing
  always_comb begin
    next_state = state;
    next_relay = relay;
    restart = 1'b0;
    case (i_mode)
      MODE_RETRIG, MODE_PULSE_MON: begin
        if (ctrl_rise) begin
          next_state = ST_TIME;
          next_relay = 1'b1;
          restart = 1'b1;
        end else if (expire) begin
          next_state = ST_IDLE;
          next_relay = 1'b0;
        end
      end
      MODE_FLASH_PAUSE, MODE_FLASH_ON: begin
        if (state == ST_IDLE && ctrl_rise) begin
          next_state = ST_TIME;
          next_relay = (i_mode == MODE_FLASH_ON);
          restart = 1'b1;
        end else if (expire) begin
          next_relay = !relay;
          restart = 1'b1;
        end
      end
      MODE_PULSE_GEN: begin
        if (state == ST_IDLE && sup_rise) begin
          next_state = ST_TIME;
          restart = 1'b1;
        end else if (state == ST_TIME && expire) begin
          next_state = ST_PULSE;
          next_relay = 1'b1;
          restart = 1'b1;
        end else if (state == ST_PULSE && expire) begin
          next_state = ST_DONE;
          next_relay = 1'b0;
        end
      end
      MODE_SIG_ONOFF: begin
        if (ctrl_rise || ctrl_fall) begin
          next_state = ST_TIME;
          next_relay = 1'b1;
          restart = 1'b1;
        end else if (expire) begin
          next_state = ST_IDLE;
          next_relay = 1'b0;
        end
      end
      MODE_LATCH: begin
        if (ctrl_rise) begin
          next_relay = !relay;
        end
      end
      MODE_MAKE_BREAK: begin
        if (ctrl_rise) begin
          next_state = ST_TIME;
          restart = 1'b1;
        end else if (ctrl_fall) begin
          next_state = ST_TOFF;
          restart = 1'b1;
        end else if (expire) begin
          next_state = (state == ST_TIME) ? ST_HOLD : ST_IDLE;
          next_relay = (state == ST_TIME);
        end
      end
      MODE_TRUE_OFF: begin
        if (sup) begin
          next_state = ST_IDLE;
          next_relay = 1'b1;
        end else if (expire) begin
          next_state = ST_IDLE;
          next_relay = 1'b0;
        end else if (sup_fall && relay) begin
          next_state = ST_TIME;
          restart = 1'b1;
        end
      end
      MODE_ON_DELAY: begin
        if (state == ST_IDLE && sup_rise) begin
          next_state = ST_TIME;
          restart = 1'b1;
        end else if (expire) begin
          next_state = ST_HOLD;
          next_relay = 1'b1;
        end
      end
      MODE_OFF_DELAY: begin
        if (ctrl) begin
          next_state = ST_HOLD;
          next_relay = 1'b1;
        end else if (ctrl_fall && relay) begin
          next_state = ST_TIME;
          restart = 1'b1;
        end else if (expire) begin
          next_state = ST_IDLE;
          next_relay = 1'b0;
        end
      end
      MODE_LEADING_SHOT, MODE_TRAILING_SHOT: begin
        if (state == ST_IDLE &&
            ((i_mode == MODE_LEADING_SHOT) ? ctrl_rise : ctrl_fall)) begin
          next_state = ST_TIME;
          next_relay = 1'b1;
          restart = 1'b1;
        end else if (expire) begin
          next_state = ST_IDLE;
          next_relay = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_relay = 1'b0;
      end
    endcase
    if (mode_chg || (!sup && i_mode != MODE_TRUE_OFF)) begin
      next_state = ST_IDLE;
      next_relay = 1'b0;
      restart = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      relay <= 1'b0;
    end else begin
      relay <= next_relay;
    end
  end

  // ==========================================================
  // Lamps
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lamp <= 1'b0;
    end else begin
      lamp <= sup && (!timing || blink);
    end
  end

  assign o_status = '{relay: relay, supply_timing_lamp: lamp, output_lamp: relay};

  // ==========================================================
  // Checks
  AST_RETRIG_ON: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_RETRIG && !mode_chg && sup && ctrl_rise)
      |=> (relay && state == ST_TIME && cnt == CNT_ZERO))
    else $error("Retrigger closure did not start output");

  AST_RETRIG_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_RETRIG && state == ST_TIME && ctrl_rise && !mode_chg && sup)
      |=> (relay && cnt == CNT_ZERO))
    else $error("Retrigger closure did not restart interval");

  AST_FLASH_START: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_FLASH_PAUSE && state == ST_IDLE && ctrl_rise && !mode_chg && sup)
      |=> (!relay && state == ST_TIME))
    else $error("Pause-first flasher did not start off");

  AST_FLASH_ON_START: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_FLASH_ON && state == ST_IDLE && ctrl_rise && !mode_chg && sup)
      |=> (relay && state == ST_TIME))
    else $error("On-first flasher did not start on");

  AST_FLASH_IGNORE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((i_mode == MODE_FLASH_ON || i_mode == MODE_FLASH_PAUSE) && state == ST_TIME
      && !expire && !mode_chg && sup)
      |=> ($stable(relay) && state == ST_TIME))
    else $error("Running flasher reacted to control");

  AST_FLASH_TOGGLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((i_mode == MODE_FLASH_ON || i_mode == MODE_FLASH_PAUSE) && expire && !mode_chg && sup)
      |=> (relay != $past(relay)))
    else $error("Flasher did not alternate at expiry");

  AST_PULSE_ON: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_PULSE_GEN && state == ST_TIME && expire && !mode_chg && sup)
      |=> (relay && state == ST_PULSE && cnt == CNT_ZERO))
    else $error("Generator pulse phase without output");

  AST_PULSE_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_PULSE_GEN && state == ST_DONE && !mode_chg && sup)
      |=> (!relay && state == ST_DONE))
    else $error("Generator left idle without supply cycle");

  AST_SIG_OPEN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_SIG_ONOFF && ctrl_fall && !mode_chg && sup)
      |=> (relay && state == ST_TIME && cnt == CNT_ZERO))
    else $error("Signal delay opening did not restart");

  AST_LATCH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_LATCH && !mode_chg && sup && ctrl_rise)
      |=> (relay != $past(relay)))
    else $error("Latch did not toggle on closure");

  AST_LATCH_OPEN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_LATCH && !mode_chg && sup && !ctrl_rise)
      |=> $stable(relay))
    else $error("Latch changed without closure");

  AST_MB_SUPPLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_MAKE_BREAK && !sup) |=> !relay)
    else $error("Make/break output on without supply");

  AST_TRUE_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_TRUE_OFF && !mode_chg && sup) |=> relay)
    else $error("True off delay not on with supply");

  AST_ON_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_ON_DELAY && state == ST_TIME && !sup) |=> (state == ST_IDLE && !relay))
    else $error("On delay kept timing without supply");

  AST_OFF_RECLOSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_OFF_DELAY && ctrl && !mode_chg && sup)
      |=> (relay && state == ST_HOLD))
    else $error("Off delay not held on while closed");

  AST_SHOT_IGNORE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((i_mode == MODE_LEADING_SHOT || i_mode == MODE_TRAILING_SHOT) && state == ST_TIME
      && !expire && !mode_chg && sup)
      |=> (relay && state == ST_TIME && cnt >= $past(cnt)))
    else $error("Single shot disturbed during interval");

  AST_TRAIL_CLOSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == MODE_TRAILING_SHOT && state == ST_IDLE && !ctrl_fall && !mode_chg)
      |=> (!relay && state == ST_IDLE))
    else $error("Trailing shot fired without opening");

  AST_LAMP_STEADY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (sup && !timing) |=> o_status.supply_timing_lamp)
    else $error("Lamp not steady while idle with supply");

  AST_MODE_CHG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    mode_chg |=> (state == ST_IDLE && !o_status.relay && !o_status.output_lamp))
    else $error("Mode change did not return to idle");

endmodule
`default_nettype wire

/* testbench/mtrs_contact_model.sv */
// Control contact and supply monitor model with contact bounce
`timescale 1ns/1ps
`default_nettype none
module mtrs_contact_model (
  input wire logic i_ctrl_req,
  input wire logic i_supply_req,
  input wire logic [7:0] i_bounce_ns,
  output var logic o_ctrl_pin,
  output var logic o_supply_pin
);
  // ==========================================================
  // Idle contacts
  initial begin
    o_ctrl_pin = 1'b0;
    o_supply_pin = 1'b0;
  end

  // ==========================================================
  // Bouncing contact, settles well inside the filter span
  always @(i_ctrl_req) begin
    repeat (2) begin
      o_ctrl_pin = i_ctrl_req;
      #(i_bounce_ns);
      o_ctrl_pin = ~i_ctrl_req;
      #(i_bounce_ns);
    end
    o_ctrl_pin = i_ctrl_req;
  end

  // ==========================================================
  // Chattering supply monitor
  always @(i_supply_req) begin
    repeat (2) begin
      o_supply_pin = i_supply_req;
      #(i_bounce_ns);
      o_supply_pin = ~i_supply_req;
      #(i_bounce_ns);
    end
    o_supply_pin = i_supply_req;
  end
endmodule
`default_nettype wire

/* testbench/multifunction_timing_relay_sequencer_tb_top.sv */
// Self-checking bench for the timing relay sequencer
`timescale 1ns/1ps
`default_nettype none
module multifunction_timing_relay_sequencer_tb_top;
  import mtrs_pkg::*;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mtrs_mode_t mode = MODE_RETRIG;
  logic [CNT_W-1:0] preset = 16'h0028;
  logic ctrl_req = 1'b0;
  logic supply_req = 1'b0;
  logic [7:0] bounce = 8'h04;
  logic prev_lamp;
  wire logic ctrl_pin;
  wire logic supply_pin;
  mtrs_out_t status;
  int num_errors = 0;
  int total_checks = 0;
  int toggles;

  // ==========================================================
  // Clock, design and far side
  always #2 clk = ~clk;

  mtrs_sequencer #(.TICK_CYC(TICK)) mtrs_sequencer_inst (
    .i_sys_clk(clk),
    .i_rst_n(rst_n),
    .i_mode(mode),
    .i_preset(preset),
    .i_ctrl(ctrl_pin),
    .i_supply(supply_pin),
    .o_status(status)
  );

  mtrs_contact_model mtrs_contact_model_inst (
    .i_ctrl_req(ctrl_req),
    .i_supply_req(supply_req),
    .i_bounce_ns(bounce),
    .o_ctrl_pin(ctrl_pin),
    .o_supply_pin(supply_pin)
  );

  // ==========================================================
  // Compare, step and verdict
  task automatic cmp(input string name, input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic st(input logic c, input logic s, input int w, input logic e);
    ctrl_req <= c;
    supply_req <= s;
    bounce <= 8'($urandom_range(8, 1));
    repeat (w * TICK) @(posedge clk);
    @(negedge clk);
    cmp("relay", status.relay, e);
    cmp("output_lamp", status.output_lamp, e);
    if (!s) cmp("supply_timing_lamp", status.supply_timing_lamp, 1'b0);
    @(posedge clk);
  endtask

  task automatic start(input mtrs_mode_t m);
    mode <= m;
    st(1'b0, 1'b0, 20, 1'b0);
  endtask

  task automatic lamp_is(input logic e);
    @(negedge clk);
    cmp("supply_timing_lamp", status.supply_timing_lamp, e);
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("[ERR] run_time expected finished seen timeout");
    wrap_up();
  end

  // ==========================================================
  // Scenarios, interval 40 ticks (600 for the final blink check), filter about 10 ticks
  initial begin
    void'($urandom(32'h6490_d147));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    start(MODE_RETRIG);
    st(0, 1, 20, 0);
    lamp_is(1'b1);
    st(1, 1, 20, 1);
    st(0, 1, 12, 1);
    st(1, 1, 24, 1);
    st(1, 1, 40, 0);
    start(MODE_FLASH_PAUSE);
    st(0, 1, 20, 0);
    st(1, 1, 20, 0);
    st(1, 1, 40, 1);
    st(0, 1, 40, 0);
    st(1, 1, 40, 1);
    st(1, 0, 20, 0);
    start(MODE_FLASH_ON);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(1, 1, 40, 0);
    st(0, 1, 40, 1);
    st(0, 1, 40, 0);
    start(MODE_PULSE_GEN);
    st(0, 1, 20, 0);
    st(0, 1, 40, 1);
    st(0, 1, 480, 1);
    st(0, 1, 30, 0);
    st(1, 1, 600, 0);
    st(0, 0, 20, 0);
    st(0, 1, 60, 1);
    start(MODE_SIG_ONOFF);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(1, 1, 40, 0);
    st(0, 1, 20, 1);
    st(0, 1, 40, 0);
    st(1, 1, 15, 1);
    st(0, 1, 45, 1);
    st(0, 1, 20, 0);
    start(MODE_LATCH);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(0, 1, 20, 1);
    st(1, 1, 20, 0);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    mode <= MODE_LEADING_SHOT;
    st(1, 1, 5, 0);
    start(MODE_MAKE_BREAK);
    st(0, 1, 20, 0);
    st(1, 1, 20, 0);
    st(1, 1, 40, 1);
    st(0, 1, 20, 1);
    st(0, 1, 40, 0);
    st(1, 1, 60, 1);
    st(1, 0, 20, 0);
    start(MODE_TRUE_OFF);
    st(0, 1, 20, 1);
    st(0, 0, 20, 1);
    st(0, 0, 40, 0);
    st(0, 0, 40, 0);
    st(0, 1, 20, 1);
    start(MODE_ON_DELAY);
    st(0, 1, 20, 0);
    st(0, 1, 40, 1);
    st(0, 0, 20, 0);
    st(0, 1, 30, 0);
    st(0, 0, 20, 0);
    st(0, 1, 45, 0);
    st(0, 1, 30, 1);
    start(MODE_OFF_DELAY);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(0, 1, 20, 1);
    st(1, 1, 30, 1);
    st(0, 1, 45, 1);
    st(0, 1, 20, 0);
    start(MODE_LEADING_SHOT);
    st(0, 1, 20, 0);
    st(1, 1, 15, 1);
    st(0, 1, 12, 1);
    st(1, 1, 35, 0);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(1, 1, 40, 0);
    start(MODE_TRAILING_SHOT);
    st(0, 1, 20, 0);
    st(1, 1, 20, 0);
    st(0, 1, 20, 1);
    st(1, 1, 15, 1);
    st(0, 1, 35, 0);
    st(1, 1, 20, 0);
    st(0, 1, 20, 1);
    st(0, 1, 40, 0);
    start(MODE_PULSE_MON);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    st(0, 1, 15, 1);
    st(1, 1, 30, 1);
    st(1, 1, 40, 0);
    st(0, 1, 20, 0);
    st(1, 1, 20, 1);
    preset <= 16'h0258;
    start(MODE_ON_DELAY);
    st(0, 1, 20, 0);
    toggles = 0;
    prev_lamp = status.supply_timing_lamp;
    repeat (560 * TICK) begin
      @(negedge clk);
      if (status.supply_timing_lamp !== prev_lamp) toggles++;
      prev_lamp = status.supply_timing_lamp;
    end
    cmp("lamp_blinks", toggles >= 2, 1'b1);
    @(posedge clk);
    st(0, 1, 60, 1);
    lamp_is(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
